// >>> src/pio_block.sv
`timescale 1ns/10ps
`default_nettype none
`include "pio_params.svh"
module pio_block
   import pio_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire logic [11:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [11:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic ADDRESS_ENABLE_STRAP_N,
   input wire logic [31:0] PIN_IN,
   output logic [31:0] PIN_OUT,
   output logic [31:0] PIN_OE,
   output logic [31:0] PULL_UP_EN,
   output logic [31:0] PULL_DOWN_EN,
   input wire logic [31:0] NORMAL_OUT,
   input wire logic [31:0] NORMAL_OE,
   output logic [31:0] NORMAL_IN
);

   // register index times four gives the byte address
   function automatic pio_sel_type pio_decode(input logic [11:0] addr);
      pio_sel_type sel;
      sel = PIO_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         case (addr[11:2])
            {2'h0, `PIO_IDX_MODE_LOW}: sel = PIO_SEL_MODE_LOW;
            {2'h0, `PIO_IDX_DIR_LOW}: sel = PIO_SEL_DIR_LOW;
            {2'h0, `PIO_IDX_LEVEL_LOW}: sel = PIO_SEL_LEVEL_LOW;
            {2'h0, `PIO_IDX_MODE_HIGH}: sel = PIO_SEL_MODE_HIGH;
            {2'h0, `PIO_IDX_DIR_HIGH}: sel = PIO_SEL_DIR_HIGH;
            {2'h0, `PIO_IDX_LEVEL_HIGH}: sel = PIO_SEL_LEVEL_HIGH;
            default: sel = PIO_SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   function automatic logic [15:0] pio_merge(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

   // write channel
   logic aw_full_ff, nxt_aw_full;
   logic [11:0] aw_addr_ff, nxt_aw_addr;
   logic w_full_ff, nxt_w_full;
   logic [31:0] w_data_ff, nxt_w_data;
   logic [3:0] w_strb_ff, nxt_w_strb;
   logic awready_ff, wready_ff, bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic wr_go;
   pio_sel_type wsel;

   assign wr_go = aw_full_ff & w_full_ff & ~bvalid_ff;
   assign wsel = pio_decode(aw_addr_ff);

   always_comb begin
      nxt_aw_full = aw_full_ff;
      nxt_aw_addr = aw_addr_ff;
      nxt_w_full = w_full_ff;
      nxt_w_data = w_data_ff;
      nxt_w_strb = w_strb_ff;
      nxt_bvalid = bvalid_ff & ~BREADY;
      nxt_bresp = bresp_ff;
      if (AWVALID & awready_ff) begin
         nxt_aw_full = 1'b1;
         nxt_aw_addr = AWADDR;
      end
      if (WVALID & wready_ff) begin
         nxt_w_full = 1'b1;
         nxt_w_data = WDATA;
         nxt_w_strb = WSTRB;
      end
      if (wr_go) begin
         nxt_aw_full = 1'b0;
         nxt_w_full = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = (wsel == PIO_SEL_NONE) ? `PIO_RESP_SLVERR : `PIO_RESP_OKAY;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         aw_full_ff <= 1'b0;
         aw_addr_ff <= 12'h000;
         w_full_ff <= 1'b0;
         w_data_ff <= 32'h00000000;
         w_strb_ff <= 4'h0;
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         bresp_ff <= `PIO_RESP_OKAY;
      end else begin
         aw_full_ff <= nxt_aw_full;
         aw_addr_ff <= nxt_aw_addr;
         w_full_ff <= nxt_w_full;
         w_data_ff <= nxt_w_data;
         w_strb_ff <= nxt_w_strb;
         awready_ff <= ~nxt_aw_full;
         wready_ff <= ~nxt_w_full;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
      end
   end

   // configuration and level registers
   logic [31:0] mode_ff, nxt_mode;
   logic [31:0] dir_ff, nxt_dir;
   logic [31:0] level_ff, nxt_level;
   logic [15:0] strap_mask;

   // strap is a plain input level; the sync reset samples it each reset cycle
   assign strap_mask = ADDRESS_ENABLE_STRAP_N ? 16'h0000 : `PIO_STRAP_MASK_HIGH;

   always_comb begin
      nxt_mode = mode_ff;
      nxt_dir = dir_ff;
      nxt_level = level_ff;
      if (wr_go) begin
         case (wsel)
            PIO_SEL_MODE_LOW: nxt_mode[15:0] = pio_merge(mode_ff[15:0], w_data_ff, w_strb_ff);
            PIO_SEL_MODE_HIGH: nxt_mode[31:16] = pio_merge(mode_ff[31:16], w_data_ff, w_strb_ff);
            PIO_SEL_DIR_LOW: nxt_dir[15:0] = pio_merge(dir_ff[15:0], w_data_ff, w_strb_ff);
            PIO_SEL_DIR_HIGH: nxt_dir[31:16] = pio_merge(dir_ff[31:16], w_data_ff, w_strb_ff);
            PIO_SEL_LEVEL_LOW: nxt_level[15:0] = pio_merge(level_ff[15:0], w_data_ff, w_strb_ff);
            PIO_SEL_LEVEL_HIGH: nxt_level[31:16] = pio_merge(level_ff[31:16], w_data_ff, w_strb_ff);
            default: nxt_mode = mode_ff;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         mode_ff <= {`PIO_RST_MODE, `PIO_RST_MODE};
         dir_ff <= {`PIO_RST_DIR_HIGH & ~strap_mask, `PIO_RST_DIR_LOW};
         // data is undefined to software; zero keeps simulation clean
         level_ff <= {`PIO_RST_LEVEL, `PIO_RST_LEVEL};
      end else begin
         mode_ff <= nxt_mode;
         dir_ff <= nxt_dir;
         level_ff <= nxt_level;
      end
   end

   // pin logic
   // a literal cannot be bit-selected, so the mask lives in a named constant
   localparam logic [31:0] pulldown_mask = `PIO_PULLDOWN_MASK;
   logic [31:0] is_normal, is_out, is_pulled;
   logic [31:0] nxt_pin_out, nxt_pin_oe, nxt_pull_up, nxt_pull_down, nxt_normal_in;
   logic [31:0] pin_smp_ff, pin_out_ff, pin_oe_ff, pull_up_ff, pull_down_ff, normal_in_ff;
   logic [31:0] level_view;

   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_pin
         assign is_normal[gi] = ~mode_ff[gi] & ~dir_ff[gi];
         assign is_out[gi] = mode_ff[gi] & ~dir_ff[gi];
         assign is_pulled[gi] = ~mode_ff[gi] & dir_ff[gi];
         assign nxt_pin_out[gi] = is_normal[gi] ? NORMAL_OUT[gi] : level_ff[gi];
         assign nxt_pin_oe[gi] = is_normal[gi] ? NORMAL_OE[gi] : is_out[gi];
         assign nxt_pull_up[gi] = is_pulled[gi] & ~pulldown_mask[gi];
         assign nxt_pull_down[gi] = is_pulled[gi] & pulldown_mask[gi];
         // peripheral sees a quiet zero once the pin is taken over
         assign nxt_normal_in[gi] = is_normal[gi] & PIN_IN[gi];
         assign level_view[gi] = is_out[gi] ? level_ff[gi] : pin_smp_ff[gi];
      end
   endgenerate

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         pin_smp_ff <= 32'h00000000;
         pin_out_ff <= 32'h00000000;
         pin_oe_ff <= 32'h00000000;
         pull_up_ff <= 32'h00000000;
         pull_down_ff <= 32'h00000000;
         normal_in_ff <= 32'h00000000;
      end else begin
         pin_smp_ff <= PIN_IN;
         pin_out_ff <= nxt_pin_out;
         pin_oe_ff <= nxt_pin_oe;
         pull_up_ff <= nxt_pull_up;
         pull_down_ff <= nxt_pull_down;
         normal_in_ff <= nxt_normal_in;
      end
   end

   // read channel
   logic arready_ff, rvalid_ff, nxt_rvalid, rd_go;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;
   pio_sel_type rsel;

   assign rd_go = ARVALID & arready_ff;
   assign rsel = pio_decode(ARADDR);

   always_comb begin
      nxt_rvalid = rvalid_ff & ~RREADY;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (rd_go) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = `PIO_RESP_OKAY;
         case (rsel)
            PIO_SEL_MODE_LOW: nxt_rdata = {16'h0000, mode_ff[15:0]};
            PIO_SEL_MODE_HIGH: nxt_rdata = {16'h0000, mode_ff[31:16]};
            PIO_SEL_DIR_LOW: nxt_rdata = {16'h0000, dir_ff[15:0]};
            PIO_SEL_DIR_HIGH: nxt_rdata = {16'h0000, dir_ff[31:16]};
            PIO_SEL_LEVEL_LOW: nxt_rdata = {16'h0000, level_view[15:0]};
            PIO_SEL_LEVEL_HIGH: nxt_rdata = {16'h0000, level_view[31:16]};
            default: begin
               nxt_rdata = 32'h00000000;
               nxt_rresp = `PIO_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= `PIO_RESP_OKAY;
      end else begin
         arready_ff <= ~nxt_rvalid;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   assign AWREADY = awready_ff;
   assign WREADY = wready_ff;
   assign BVALID = bvalid_ff;
   assign BRESP = bresp_ff;
   assign ARREADY = arready_ff;
   assign RVALID = rvalid_ff;
   assign RDATA = rdata_ff;
   assign RRESP = rresp_ff;
   assign PIN_OUT = pin_out_ff;
   assign PIN_OE = pin_oe_ff;
   assign PULL_UP_EN = pull_up_ff;
   assign PULL_DOWN_EN = pull_down_ff;
   assign NORMAL_IN = normal_in_ff;

   // assertions; pin checks start only from a sampled idle reset, as pins lag config by one edge
   property p_reset_config;
      @(posedge CORE_CLK) SYS_RST |=> (mode_ff == 32'h00000000) && (dir_ff[15:0] == `PIO_RST_DIR_LOW);
   endproperty
   a_reset_config: assert property (p_reset_config) else $error("mode/direction reset value wrong");

   property p_strap;
      @(posedge CORE_CLK) (SYS_RST && !ADDRESS_ENABLE_STRAP_N) |=> (dir_ff[26] == 1'b0) && (dir_ff[29] == 1'b0);
   endproperty
   a_strap: assert property (p_strap) else $error("strap pins not returned to normal");

   property p_output_drive;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         !SYS_RST |=> ((PIN_OE & $past(is_out)) == $past(is_out))
            && ((PIN_OUT & $past(is_out)) == $past(level_ff & is_out));
   endproperty
   a_output_drive: assert property (p_output_drive) else $error("output pin not driving its data");

   property p_input_released;
      @(posedge CORE_CLK) disable iff (SYS_RST) !SYS_RST |=> (PIN_OE & $past(dir_ff)) == 32'h00000000;
   endproperty
   a_input_released: assert property (p_input_released) else $error("input pin still driven");

   property p_pulls;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         !SYS_RST |=> ((PULL_UP_EN | PULL_DOWN_EN) == $past(is_pulled))
            && ((PULL_DOWN_EN & ~pulldown_mask) == 32'h0);
   endproperty
   a_pulls: assert property (p_pulls) else $error("pull resistor selection wrong");

   property p_normal_pass;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         !SYS_RST |=> ((NORMAL_IN & ~$past(is_normal)) == 32'h0)
            && ((PIN_OE & $past(is_normal)) == $past(NORMAL_OE & is_normal));
   endproperty
   a_normal_pass: assert property (p_normal_pass) else $error("normal function leaks into pin");

   sequence s_mode_low_write;
      wr_go && (wsel == PIO_SEL_MODE_LOW) && (w_strb_ff[1:0] == 2'h3);
   endsequence
   property p_mode_write;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         s_mode_low_write |=> BVALID && (mode_ff[15:0] == $past(w_data_ff[15:0]));
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write not applied");

   sequence s_mode_low_read;
      rd_go && (rsel == PIO_SEL_MODE_LOW);
   endsequence
   property p_mode_read;
      @(posedge CORE_CLK) disable iff (SYS_RST) s_mode_low_read |=> RVALID && (RDATA == {16'h0000, $past(mode_ff[15:0])});
   endproperty
   a_mode_read: assert property (p_mode_read) else $error("mode read back wrong");

   property p_level_read;
      @(posedge CORE_CLK) disable iff (SYS_RST)
         (rd_go && (rsel == PIO_SEL_LEVEL_HIGH)) |=> RDATA[15:0] == $past(level_view[31:16]);
   endproperty
   a_level_read: assert property (p_level_read) else $error("level read wrong");

endmodule // pio_block
`default_nettype wire

// >>> src/pio_params.svh
// Summary of operation
// - mode/direction pairs: 00 normal, 01 pulled input, 10 output, 11 bare input.
// - after reset all 32 pins are normal function or pulled input.
// - pins normally active-high outputs get pulldown; others pullup or normal.
// - upper mode register covers pins 31..16, msb is pin 31, resets zero.
// - lower mode register covers pins 15..0, same order, resets zero.
// - direction one means input; zero means output, or normal with mode zero.
// - upper direction register covers pins 31..16 and resets to all ones.
// - lower direction register resets so pins 4..9 normal, others pulled inputs.
// - output pins drive their data bit uninverted.
// - input pins show the sampled pin level, uninverted, in data reads.
// - data registers map pins like mode registers; reset value undefined.
// - open drain: data bit held zero, direction bit carries the value.
// - strap low during reset returns the two strap pins to normal function.
// - normal-default pins pull up as inputs, except ready input pulls down.
// - a programmable pin is cut off from its normal peripheral function.
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH
`define PIO_IDX_MODE_LOW 8'h70
`define PIO_IDX_DIR_LOW 8'h72
`define PIO_IDX_LEVEL_LOW 8'h74
`define PIO_IDX_MODE_HIGH 8'h76
`define PIO_IDX_DIR_HIGH 8'h78
`define PIO_IDX_LEVEL_HIGH 8'h7A
`define PIO_RST_MODE 16'h0000
`define PIO_RST_DIR_LOW 16'hFC0F
`define PIO_RST_DIR_HIGH 16'hFFFF
`define PIO_RST_LEVEL 16'h0000
`define PIO_STRAP_MASK_HIGH 16'h2400
`define PIO_PULLDOWN_MASK 32'h00C00442
`define PIO_RESP_OKAY 2'h0
`define PIO_RESP_SLVERR 2'h2
`endif

// >>> src/pio_pkg.sv
package pio_pkg;
   typedef enum {
      PIO_SEL_MODE_LOW,
      PIO_SEL_DIR_LOW,
      PIO_SEL_LEVEL_LOW,
      PIO_SEL_MODE_HIGH,
      PIO_SEL_DIR_HIGH,
      PIO_SEL_LEVEL_HIGH,
      PIO_SEL_NONE
   } pio_sel_type;
endpackage

// >>> tb/pio_block_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "pio_params.svh"
module pio_block_bench;
   localparam logic [1:0] ok = `PIO_RESP_OKAY;
   localparam logic [1:0] err = `PIO_RESP_SLVERR;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic strap_n = 1'b1;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic [31:0] ext_val = 32'h00000000, ext_oe = 32'h00000000;
   logic [31:0] normal_out = 32'hA5A55A5A, normal_oe = 32'hFFFFFFFF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, pin_in, pin_out, pin_oe, pu, pd, normal_in;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   always #12.5 clk = ~clk;
   pio_block pio_block_inst (.CORE_CLK(clk), .SYS_RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .ADDRESS_ENABLE_STRAP_N(strap_n),
      .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PULL_UP_EN(pu), .PULL_DOWN_EN(pd),
      .NORMAL_OUT(normal_out), .NORMAL_OE(normal_oe), .NORMAL_IN(normal_in));
   pio_pins_model pio_pins_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pu),
      .pull_down_en(pd), .ext_val(ext_val), .ext_oe(ext_oe), .pin_level(pin_in));
   function automatic logic [11:0] adr(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge clk);
      chk("write response", {30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
   endtask
   task automatic rdc(input string what, input logic [11:0] a, input logic [15:0] exp, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      chk(what, rdata, {16'h0000, exp});
      chk("read response", {30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
   endtask
   // pins follow a config write one edge after it lands
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   task summarize();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      settle();
      rdc("mode low", adr(`PIO_IDX_MODE_LOW), 16'h0000, ok);
      rdc("mode high", adr(`PIO_IDX_MODE_HIGH), 16'h0000, ok);
      rdc("dir low", adr(`PIO_IDX_DIR_LOW), 16'hFC0F, ok);
      rdc("dir high", adr(`PIO_IDX_DIR_HIGH), 16'hFFFF, ok);
      chk("reset oe", pin_oe, 32'h000003F0);
      chk("reset pull up", pu, 32'hFF3FF80D);
      chk("reset pull down", pd, 32'h00C00402);
      chk("normal drive", pin_out & 32'h000003F0, 32'h00000250);
      chk("normal in", normal_in, 32'h00000250);
      $display("test reset done");
      wr(adr(`PIO_IDX_MODE_LOW), 16'hFFFF, ok);
      wr(adr(`PIO_IDX_DIR_LOW), 16'h0000, ok);
      wr(adr(`PIO_IDX_LEVEL_LOW), 16'hA5C3, ok);
      settle();
      chk("out oe", {16'h0000, pin_oe[15:0]}, 32'h0000FFFF);
      chk("out value", {16'h0000, pin_out[15:0]}, 32'h0000A5C3);
      chk("normal cut", normal_in, 32'h00000000);
      rdc("level latch", adr(`PIO_IDX_LEVEL_LOW), 16'hA5C3, ok);
      rdc("mode back", adr(`PIO_IDX_MODE_LOW), 16'hFFFF, ok);
      $display("test output done");
      wr(adr(`PIO_IDX_LEVEL_LOW), 16'h0000, ok);
      wr(adr(`PIO_IDX_DIR_LOW), 16'h00FF, ok);
      ext_oe <= 32'h000000FF;
      ext_val <= 32'hFFFFFFFF;
      settle();
      chk("drain oe", {16'h0000, pin_oe[15:0]}, 32'h0000FF00);
      chk("drain low", {24'h000000, pin_out[15:8]}, 32'h00000000);
      rdc("drain level", adr(`PIO_IDX_LEVEL_LOW), 16'h00FF, ok);
      $display("test open drain done");
      wr(adr(`PIO_IDX_MODE_HIGH), 16'hFFFF, ok);
      ext_oe <= 32'hFFFF0000;
      ext_val <= 32'h12340000;
      settle();
      chk("bare pulls", {16'h0000, pu[31:16] | pd[31:16]}, 32'h00000000);
      rdc("input level", adr(`PIO_IDX_LEVEL_HIGH), 16'h1234, ok);
      wr(adr(`PIO_IDX_MODE_HIGH), 16'h0000, ok);
      wr(adr(`PIO_IDX_MODE_LOW), 16'h0000, ok);
      wr(adr(`PIO_IDX_DIR_LOW), 16'hFFFF, ok);
      ext_oe <= 32'h00000000;
      settle();
      chk("pull up all", pu, 32'hFF3FFBBD);
      chk("pull down all", pd, `PIO_PULLDOWN_MASK);
      rdc("pulled level", adr(`PIO_IDX_LEVEL_HIGH), 16'hFF3F, ok);
      $display("test input done");
      wr(12'h1C4, 16'h0000, err);
      rdc("unmapped", 12'h000, 16'h0000, err);
      rdc("misaligned", 12'h1C2, 16'h0000, err);
      rdc("dir kept", adr(`PIO_IDX_DIR_LOW), 16'hFFFF, ok);
      $display("test refusal done");
      strap_n <= 1'b0;
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      settle();
      rdc("strap dir", adr(`PIO_IDX_DIR_HIGH), 16'hFFFF & ~`PIO_STRAP_MASK_HIGH, ok);
      chk("strap oe", pin_oe, 32'h240003F0);
      $display("test strap done");
      summarize();
   end
endmodule // pio_block_bench
`default_nettype wire

// >>> tb/pio_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
module pio_pins_model (
   input wire logic clk,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] pull_up_en,
   input wire logic [31:0] pull_down_en,
   input wire logic [31:0] ext_val,
   input wire logic [31:0] ext_oe,
   output logic [31:0] pin_level
);
   logic [31:0] last_ff = 32'h00000000;
   // a floating pin wanders so a stale level never passes for a real one
   always_comb begin
      pin_level = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
         | (~pin_oe & ~ext_oe & (pull_up_en | (~pull_down_en & ~last_ff)));
   end
   always @(posedge clk) begin
      last_ff <= pin_level;
   end
endmodule // pio_pins_model
`default_nettype wire
